// >>> rtl/trig_cond.sv
/*
 * Trigger input conditioner: two filtered inputs or a software strike start a
 * delayed burst of frames for the exposure sequencer.
 * Assumes the sequencer answers each EXPOSE_START with one EXPOSE_DONE pulse
 * at the end of that frame's exposure, and that all inputs are synchronous
 * except IN_LINE, which is synchronised inside.
 */
// The placing of the registers and the plain strobed port were decided locally.
`timescale 1ns/100ps
`default_nettype none

`include "trig_regs.svh"

module trig_cond
    import trig_pkg::*;
#(
    parameter int DELAY_W = 22,
    parameter int BURST_W = 17
) (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    input  wire logic [1:0]  IN_LINE,
    input  wire logic        EXPOSE_DONE,
    output logic             EXPOSE_START,
    output logic             ACQ_BUSY,
    output logic             DROP_PULSE
);
    localparam int TICK_DIV = `TRIG_TICK_NS / `TRIG_CLK_NS;

    logic               tick;
    logic [1:0]         line;
    logic [1:0]         filt;
    logic [1:0]         filt_d_r;
    logic [1:0]         in_hit;

    logic               trig_allow_r;
    src_t               trig_origin_sel_r;
    logic               trig_active_level_r;
    logic               in_index_r;
    logic               notify_r;
    logic [1:0]         in_line_invert_r;
    logic [7:0]         in_line_filter_len_r [2];
    logic [BURST_W-1:0] frame_burst_count_r;
    logic [DELAY_W-1:0] trig_wait_us_r;
    logic               drop_r;

    state_t             state_r;
    state_t             state_nxt;
    logic [DELAY_W-1:0] wait_cnt_r;
    logic [BURST_W-1:0] frames_left_r;
    logic               sw_trig_strike;
    logic               trig_event;
    logic               trig_take;
    logic               trig_drop;
    logic               busy;
    logic [31:0]        rd_val;

    // The burst counter holds 65536 and the delay must fit a word.
    generate
        if (BURST_W < 17 || BURST_W > 31) begin : g_chk_burst
            $error("trig_cond: BURST_W must be 17 to 31");
        end
        if (DELAY_W < 1 || DELAY_W > 32) begin : g_chk_delay
            $error("trig_cond: DELAY_W must be 1 to 32");
        end
    endgenerate

    // Microsecond tick shared by both filters and the delay.
    us_tick #(
        .DIV (TICK_DIV)
    ) u_tick (
        .clk  (CLOCK),
        .rst  (RST),
        .tick (tick)
    );

    // One filter per input, each with its own polarity and length.
    for (genvar i = 0; i < 2; i++) begin : g_in
        in_debounce #(
            .LEN_W (8)
        ) u_flt (
            .clk    (CLOCK),
            .rst    (RST),
            .tick   (tick),
            .din    (IN_LINE[i]),
            .invert (in_line_invert_r[i]),
            .len    (in_line_filter_len_r[i]),
            .line   (line[i]),
            .dout   (filt[i])
        );
    end

    // Register writes. Per-input fields go to the input the index names.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            trig_allow_r            <= 1'b0;
            trig_origin_sel_r       <= SRC_IN0;
            trig_active_level_r     <= `TRIG_LEVEL_RST;
            in_index_r              <= 1'b0;
            notify_r                <= 1'b0;
            in_line_invert_r        <= 2'h0;
            in_line_filter_len_r[0] <= `TRIG_LEN_RST;
            in_line_filter_len_r[1] <= `TRIG_LEN_RST;
            frame_burst_count_r     <= BURST_W'(`TRIG_BURST_RST);
            trig_wait_us_r          <= '0;
        end else if (WR) begin
            case (ADDR)
                `TRIG_CTRL_OFS: begin
                    trig_allow_r        <= WDATA[`TRIG_CTRL_ALLOW];
                    trig_origin_sel_r   <= src_t'(WDATA[`TRIG_CTRL_SRC_LSB +: 2]);
                    trig_active_level_r <= WDATA[`TRIG_CTRL_LEVEL];
                    in_index_r          <= WDATA[`TRIG_CTRL_INDEX];
                    notify_r            <= WDATA[`TRIG_CTRL_NOTIFY];
                end
                `TRIG_BURST_OFS: begin
                    frame_burst_count_r <= WDATA[BURST_W-1:0];
                end
                `TRIG_WAIT_OFS: begin
                    trig_wait_us_r <= WDATA[DELAY_W-1:0];
                end
                `TRIG_INCFG_OFS: begin
                    in_line_invert_r[in_index_r]     <= WDATA[`TRIG_INCFG_INVERT];
                    in_line_filter_len_r[in_index_r] <= WDATA[`TRIG_INCFG_LEN_LSB +: 8];
                end
                default: begin
                end
            endcase
        end
    end

    // A strike counts only while software is the source.
    assign sw_trig_strike = WR && (ADDR == `TRIG_STRIKE_OFS) && WDATA[0]
                            && (trig_origin_sel_r == SRC_SW);

    // Filtered lines of the previous cycle, for entry into the active level.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            filt_d_r <= 2'h0;
        end else begin
            filt_d_r <= filt;
        end
    end

    // A line fires when it enters the chosen active level. Holding the level
    // does not re-fire, so a long pulse yields one burst only.
    assign in_hit[0] = (filt[0] == trig_active_level_r)
                       && (filt_d_r[0] != trig_active_level_r);
    assign in_hit[1] = (filt[1] == trig_active_level_r)
                       && (filt_d_r[1] != trig_active_level_r);

    // Source choice; the unused code never fires.
    always_comb begin
        case (trig_origin_sel_r)
            SRC_IN0: trig_event = in_hit[0];
            SRC_IN1: trig_event = in_hit[1];
            SRC_SW:  trig_event = sw_trig_strike;
            default: trig_event = 1'b0;
        endcase
    end

    assign busy      = (state_r != ST_IDLE);
    assign trig_take = trig_allow_r && trig_event && !busy;
    assign trig_drop = trig_allow_r && trig_event && busy;

    // Sequencer: delay, then one start per frame, each awaiting its done.
    always_comb begin
        case (state_r)
            ST_IDLE: begin
                if (!trig_take) begin
                    state_nxt = ST_IDLE;
                end else if (trig_wait_us_r == '0) begin
                    state_nxt = ST_START;
                end else begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (tick && wait_cnt_r == DELAY_W'(1)) begin
                    state_nxt = ST_START;
                end else begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_START: begin
                state_nxt = ST_EXPOSE;
            end
            ST_EXPOSE: begin
                if (!EXPOSE_DONE) begin
                    state_nxt = ST_EXPOSE;
                end else if (frames_left_r > BURST_W'(1)) begin
                    state_nxt = ST_START;
                end else begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Delay counts whole microsecond ticks, so the wait may run short by
    // less than one tick; finer timing would need a second counter.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            wait_cnt_r <= '0;
        end else if (trig_take) begin
            wait_cnt_r <= trig_wait_us_r;
        end else if (state_r == ST_WAIT && tick) begin
            wait_cnt_r <= wait_cnt_r - 1'b1;
        end
    end

    // Frames still owed; a count of zero is served as one.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            frames_left_r <= '0;
        end else if (trig_take) begin
            frames_left_r <= (frame_burst_count_r == '0) ? BURST_W'(1)
                                                         : frame_burst_count_r;
        end else if (state_r == ST_EXPOSE && EXPOSE_DONE) begin
            frames_left_r <= frames_left_r - 1'b1;
        end
    end

    // Registered sequencer outputs.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            EXPOSE_START <= 1'b0;
            ACQ_BUSY     <= 1'b0;
        end else begin
            EXPOSE_START <= (state_nxt == ST_START);
            ACQ_BUSY     <= (state_nxt != ST_IDLE);
        end
    end

    // Discard notice: sticky flag cleared by a write of one, set wins.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            drop_r <= 1'b0;
        end else if (trig_drop) begin
            drop_r <= 1'b1;
        end else if (WR && ADDR == `TRIG_STAT_OFS && WDATA[`TRIG_STAT_DROP]) begin
            drop_r <= 1'b0;
        end
    end

    // The pulse is sent only when software asked for notice.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            DROP_PULSE <= 1'b0;
        end else begin
            DROP_PULSE <= trig_drop && notify_r;
        end
    end

    // Read multiplexer.
    always_comb begin
        rd_val = 32'h0000_0000;
        case (ADDR)
            `TRIG_CTRL_OFS: begin
                rd_val[`TRIG_CTRL_ALLOW]          = trig_allow_r;
                rd_val[`TRIG_CTRL_SRC_LSB +: 2]   = trig_origin_sel_r;
                rd_val[`TRIG_CTRL_LEVEL]          = trig_active_level_r;
                rd_val[`TRIG_CTRL_INDEX]          = in_index_r;
                rd_val[`TRIG_CTRL_NOTIFY]         = notify_r;
            end
            `TRIG_BURST_OFS: begin
                rd_val[BURST_W-1:0] = frame_burst_count_r;
            end
            `TRIG_WAIT_OFS: begin
                rd_val[DELAY_W-1:0] = trig_wait_us_r;
            end
            `TRIG_INCFG_OFS: begin
                rd_val[`TRIG_INCFG_INVERT]        = in_line_invert_r[in_index_r];
                rd_val[`TRIG_INCFG_LEN_LSB +: 8]  = in_line_filter_len_r[in_index_r];
            end
            `TRIG_STAT_OFS: begin
                rd_val[`TRIG_STAT_LINE] = line[in_index_r];
                rd_val[`TRIG_STAT_BUSY] = busy;
                rd_val[`TRIG_STAT_DROP] = drop_r;
            end
            default: begin
                rd_val = 32'h0000_0000;
            end
        endcase
    end

    // Read data stand for one cycle after the strobe, zero otherwise.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            RDATA <= 32'h0000_0000;
        end else begin
            RDATA <= RD ? rd_val : 32'h0000_0000;
        end
    end

endmodule

`default_nettype wire

// >>> include/trig_regs.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * trigger input conditioner.
 * Assumes a 100 MHz system clock and a word-wide register port.
 */
`ifndef TRIG_REGS_SVH
`define TRIG_REGS_SVH

// Byte offsets on the register port.
`define TRIG_CTRL_OFS      8'h00
`define TRIG_STRIKE_OFS    8'h04
`define TRIG_BURST_OFS     8'h08
`define TRIG_WAIT_OFS      8'h0C
`define TRIG_INCFG_OFS     8'h10
`define TRIG_STAT_OFS      8'h14

// Control register fields.
`define TRIG_CTRL_ALLOW    0
`define TRIG_CTRL_SRC_LSB  1
`define TRIG_CTRL_LEVEL    3
`define TRIG_CTRL_INDEX    4
`define TRIG_CTRL_NOTIFY   5

// Input configuration fields, applied to the input chosen by the index.
`define TRIG_INCFG_INVERT  0
`define TRIG_INCFG_LEN_LSB 8

// Status fields.
`define TRIG_STAT_LINE     0
`define TRIG_STAT_BUSY     1
`define TRIG_STAT_DROP     2

// Reset values.
`define TRIG_LEVEL_RST     1'b1
`define TRIG_BURST_RST     17'h00001
`define TRIG_LEN_RST       8'h01

// Timing: clock period and tick period in ns.
`define TRIG_CLK_NS        10
`define TRIG_TICK_NS       1000

`endif

// >>> include/trig_pkg.sv
/*
 * Types shared by the trigger input conditioner.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package trig_pkg;

    // Trigger origin codes.
    typedef enum logic [1:0] {
        SRC_IN0 = 2'h0,
        SRC_IN1 = 2'h1,
        SRC_SW  = 2'h2
    } src_t;

    // Acquisition sequencer states, one-hot.
    typedef enum logic [3:0] {
        ST_IDLE   = 4'h1,
        ST_WAIT   = 4'h2,
        ST_START  = 4'h4,
        ST_EXPOSE = 4'h8
    } state_t;

endpackage

// >>> rtl/us_tick.sv
/*
 * Divider that pulses one cycle in every DIV cycles.
 * Assumes one free running clock and a synchronous active high reset.
 */
`timescale 1ns/100ps
`default_nettype none

module us_tick #(
    parameter int DIV = 100
) (
    input  wire logic clk,
    input  wire logic rst,
    output logic      tick
);
    localparam int W = $clog2(DIV);

    logic [W-1:0] cnt_r;

    // A divide of one would need a zero-width counter.
    generate
        if (DIV < 2) begin : g_chk
            $error("us_tick: DIV must be at least 2");
        end
    endgenerate

    // Free running count; the tick marks the wrap.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            tick  <= 1'b0;
        end else if (cnt_r == W'(DIV - 1)) begin
            cnt_r <= '0;
            tick  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + 1'b1;
            tick  <= 1'b0;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/in_debounce.sv
/*
 * One general input: two-flop synchroniser, polarity, debounce filter.
 * Assumes a one-cycle tick every microsecond from the block's divider.
 */
`timescale 1ns/100ps
`default_nettype none

module in_debounce #(
    parameter int LEN_W = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             tick,
    input  wire logic             din,
    input  wire logic             invert,
    input  wire logic [LEN_W-1:0] len,
    output logic                  line,
    output logic                  dout
);
    logic             s1_r;
    logic             s2_r;
    logic             lvl;
    logic [LEN_W-1:0] cnt_r;
    logic [LEN_W-1:0] need;

    generate
        if (LEN_W < 1 || LEN_W > 16) begin : g_chk
            $error("in_debounce: LEN_W out of range");
        end
    endgenerate

    // The first flop feeds only the second.
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_r <= 1'b0;
            s2_r <= 1'b0;
        end else begin
            s1_r <= din;
            s2_r <= s1_r;
        end
    end

    assign line = s2_r;
    assign lvl  = s2_r ^ invert;
    // A length of zero would pass glitches, so it acts as one.
    assign need = (len == '0) ? LEN_W'(1) : len;

    // The output follows only after the new level held for need ticks.
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_r <= '0;
            dout  <= 1'b0;
        end else if (lvl == dout) begin
            cnt_r <= '0;
        end else if (tick) begin
            if (cnt_r + 1'b1 >= need) begin
                dout  <= lvl;
                cnt_r <= '0;
            end else begin
                cnt_r <= cnt_r + 1'b1;
            end
        end
    end

endmodule

`default_nettype wire

// >>> dv/trig_cond_assertions.sv
/*
 * Concurrent checks on the ports of the trigger input conditioner.
 * Assumes the register map of the design header and a sequencer that ends each exposure.
 */
`timescale 1ns/100ps
`default_nettype none

module trig_cond_checker (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic [7:0]  ADDR,
    input wire logic [31:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [31:0] RDATA,
    input wire logic [1:0]  IN_LINE,
    input wire logic        EXPOSE_DONE,
    input wire logic        EXPOSE_START,
    input wire logic        ACQ_BUSY,
    input wire logic        DROP_PULSE
);
    logic allow_r;

    // Shadow of the global enable, so that blocking is judged without a read back.
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            allow_r <= 1'b0;
        end else if (WR && ADDR == 8'h00) begin
            allow_r <= WDATA[0];
        end
    end

    default clocking @(posedge CLOCK); endclocking
    default disable iff (RST);

    // A frame ended and the burst still runs.
    sequence frame_more;
        EXPOSE_DONE ##1 ACQ_BUSY;
    endsequence

    // Enable stayed off across the whole acceptance latency.
    sequence held_off;
        !allow_r [*3];
    endsequence

    start_once_a: assert property (EXPOSE_START |=> !EXPOSE_START)
        else $error("exposure start longer than one cycle");
    start_busy_a: assert property (EXPOSE_START |-> ACQ_BUSY)
        else $error("exposure start outside an acquisition");
    next_frame_a: assert property (frame_more |-> EXPOSE_START)
        else $error("next frame did not start one cycle after done");
    busy_end_a: assert property ($fell(ACQ_BUSY) |-> $past(EXPOSE_DONE))
        else $error("acquisition ended without an exposure done");
    drop_busy_a: assert property (DROP_PULSE |-> $past(ACQ_BUSY) || $past(ACQ_BUSY, 2))
        else $error("drop notice while idle");
    blocked_idle_a: assert property (held_off |-> !$rose(ACQ_BUSY))
        else $error("acquisition started while triggering disabled");
    rdata_idle_a: assert property (!$past(RD) |-> RDATA == 32'h0)
        else $error("read data outside the read answer cycle");
    strike_read_a: assert property (RD && (ADDR == 8'h04 || ADDR > 8'h14) |=> RDATA == 32'h0)
        else $error("strike or unmapped read returned data");
endmodule

bind trig_cond trig_cond_checker chk (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .IN_LINE(IN_LINE), .EXPOSE_DONE(EXPOSE_DONE),
    .EXPOSE_START(EXPOSE_START), .ACQ_BUSY(ACQ_BUSY), .DROP_PULSE(DROP_PULSE));

`default_nettype wire

// >>> dv/trig_source_model.sv
/*
 * Far side model: trigger source on the two input pins and the exposure sequencer.
 * Assumes the bench calls drive right after a rising edge of clk.
 */
`timescale 1ns/100ps
`default_nettype none

module trig_source_model (
    output logic      [1:0] line = 2'h0,
    output logic            done = 1'b0,
    input  wire logic       clk,
    input  wire logic       start
);
    int left = 0;

    // Each frame start is answered by one end of exposure pulse after a fixed lag.
    always @(posedge clk) begin
        done <= (left == 1) && !start;
        if (start) begin
            left <= 20;
        end else if (left > 0) begin
            left <= left - 1;
        end
    end

    // Holds a pin level for whole microseconds; short holds are deliberate glitches.
    task automatic drive(input int idx, input logic lvl, input int us);
        line[idx] <= lvl;
        repeat (us * 100) @(posedge clk);
    endtask
endmodule

`default_nettype wire

// >>> dv/trig_cond_tb_top.sv
/*
 * Self-checking bench for the trigger input conditioner.
 * Assumes the source model and checker of dv and the design header on the include path.
 */
`timescale 1ns/100ps
`default_nettype none

module trig_cond_tb_top;
    logic        CLOCK = 1'b0;
    logic        RST   = 1'b1;
    logic [7:0]  ADDR  = 8'h00;
    logic [31:0] WDATA = 32'h0;
    logic        WR    = 1'b0;
    logic        RD    = 1'b0;
    logic [31:0] RDATA;
    logic [1:0]  IN_LINE;
    logic        EXPOSE_DONE, EXPOSE_START, ACQ_BUSY, DROP_PULSE;
    int          err_total = 0;
    int          compares = 0;
    int          starts = 0;
    int          drops = 0;

    // System clock, 10 ns period.
    always #5 CLOCK = ~CLOCK;

    trig_cond uut (.CLOCK(CLOCK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .IN_LINE(IN_LINE), .EXPOSE_DONE(EXPOSE_DONE),
        .EXPOSE_START(EXPOSE_START), .ACQ_BUSY(ACQ_BUSY), .DROP_PULSE(DROP_PULSE));
    trig_source_model src (.clk(CLOCK), .start(EXPOSE_START), .line(IN_LINE), .done(EXPOSE_DONE));

    // Counting at the edge sees each one-cycle pulse exactly once.
    always @(posedge CLOCK) begin
        if (EXPOSE_START === 1'b1) starts++;
        if (DROP_PULSE === 1'b1) drops++;
    end

    task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chk_num(input string what, input int exp, input int got);
        compares++;
        if (got != exp) begin
            err_total++;
            $display("ERROR %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    // Register cycles; the idle edge after each keeps strobes from being set twice at once.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLOCK);
        WR <= 1'b0;
        @(posedge CLOCK);
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLOCK);
        RD <= 1'b0;
        @(posedge CLOCK);
        d = RDATA;
    endtask

    function automatic logic [31:0] ctrl(input int on, input int org, input int lvl,
                                         input int idx, input int note);
        return 32'(on + org * 2 + lvl * 8 + idx * 16 + note * 32);
    endfunction

    task automatic wait_idle(input int lim);
        int n;
        n = 0;
        while (ACQ_BUSY !== 1'b0 && n < lim) begin
            @(posedge CLOCK);
            n++;
        end
        chk_num("acquisition end", 1, int'(n < lim));
    endtask

    task automatic t_regs();
        logic [7:0]  a [7] = '{8'h00, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h04, 8'h18};
        logic [31:0] e [7] = '{32'h8, 32'h1, 32'h0, 32'h100, 32'h0, 32'h0, 32'h0};
        logic [31:0] d;
        wr(8'h18, 32'hFFFF_FFFF);
        for (int i = 0; i < 7; i++) begin
            rd(a[i], d);
            chk_word("reset register", e[i], d);
        end
        wr(8'h00, ctrl(0, 0, 1, 1, 0));
        wr(8'h10, 32'h0000_0301);
        rd(8'h10, d);
        chk_word("second input config", 32'h301, d);
        wr(8'h00, ctrl(0, 0, 1, 0, 0));
        rd(8'h10, d);
        chk_word("first input config", 32'h100, d);
        $display("t_regs finished");
    endtask

    task automatic t_line();
        logic [31:0] d;
        src.drive(1, 1'b1, 1);
        rd(8'h14, d);
        chk_word("first line state", 32'h0, d);
        wr(8'h00, ctrl(0, 0, 1, 1, 0));
        rd(8'h14, d);
        chk_word("second line state", 32'h1, d);
        src.drive(1, 1'b0, 1);
        $display("t_line finished");
    endtask

    // Each input, both polarities and both levels: a glitch and the other pin are ignored.
    task automatic t_input();
        int   idx;
        int   n0;
        logic inv, lvl, act;
        for (int k = 0; k < 4; k++) begin
            idx = k % 2;
            inv = (k == 1 || k == 2);
            lvl = (k < 2);
            act = lvl ^ inv;
            wr(8'h00, ctrl(0, idx, lvl, idx, 0));
            wr(8'h10, {16'h0, 8'h05, 7'h0, inv});
            src.drive(idx, ~act, 12);
            wr(8'h00, ctrl(1, idx, lvl, idx, 0));
            n0 = starts;
            src.drive(idx, act, 3);
            src.drive(idx, ~act, 12);
            src.drive(1 - idx, 1'b1, 8);
            src.drive(1 - idx, 1'b0, 8);
            chk_num("glitch or unselected pin", n0, starts);
            src.drive(idx, act, 8);
            src.drive(idx, ~act, 12);
            wait_idle(100);
            chk_num("filtered trigger", n0 + 1, starts);
        end
        $display("t_input finished");
    endtask

    task automatic t_sw();
        logic [31:0] d;
        int          n0, d0;
        wr(8'h08, 32'h3);
        wr(8'h00, ctrl(1, 2, 1, 0, 1));
        n0 = starts;
        d0 = drops;
        wr(8'h04, 32'h1);
        wr(8'h04, 32'h1);
        wait_idle(400);
        chk_num("frames per strike", n0 + 3, starts);
        chk_num("drop notices", d0 + 1, drops);
        rd(8'h14, d);
        chk_word("status after drop", 32'h4, d);
        wr(8'h14, 32'h4);
        rd(8'h14, d);
        chk_word("status after clear", 32'h0, d);
        wr(8'h08, 32'h1);
        $display("t_sw finished");
    endtask

    // Disabled, source none and a pin source all ignore a strike.
    task automatic t_block();
        logic [31:0] c [3] = '{ctrl(0, 2, 1, 0, 0), ctrl(1, 3, 1, 0, 0), ctrl(1, 0, 0, 0, 0)};
        int          n0;
        for (int i = 0; i < 3; i++) begin
            n0 = starts;
            wr(8'h00, c[i]);
            wr(8'h04, 32'h1);
            repeat (50) @(posedge CLOCK);
            chk_num("blocked strike", n0, starts);
        end
        $display("t_block finished");
    endtask

    task automatic t_delay();
        int n;
        wr(8'h0C, 32'h14);
        wr(8'h00, ctrl(1, 2, 1, 0, 0));
        wr(8'h04, 32'h1);
        n = 1;
        while (EXPOSE_START !== 1'b1 && n < 3000) begin
            @(posedge CLOCK);
            n++;
        end
        chk_num("delay within 19 to 20 us", 1, int'(n >= 1895 && n <= 2010));
        wait_idle(100);
        $display("t_delay finished");
    endtask

    task automatic test_done();
        $display("Counts: compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs about 30000 cycles, so 60000 means a hang.
    initial begin
        #600000;
        err_total++;
        $display("ERROR watchdog expected finish seen timeout");
        test_done();
    end

    initial begin
        repeat (5) @(posedge CLOCK);
        RST <= 1'b0;
        @(posedge CLOCK);
        t_regs();
        t_line();
        t_input();
        t_sw();
        t_block();
        t_delay();
        test_done();
    end
endmodule

`default_nettype wire
